// ### design/ssd_pkg.sv
// Shared constants and state codes for the synchronous burst SRAM cycle decoder.
`default_nettype none

package ssd_pkg;

  // Lane layout: eight data bits plus one parity bit per byte lane.
  localparam int BYTE_W = 8;
  localparam int LANE_W = 9;
  localparam int LANES_X36 = 4;
  localparam int LANES_X18 = 2;
  localparam int ADDR_W_X36 = 19;

  // Burst counter width and step.
  localparam int STEP_W = 2;
  localparam logic [1:0] STEP_ZERO = 2'h0;
  localparam logic [1:0] STEP_ONE = 2'h1;

  // Burst order selected by the mode input.
  localparam logic MODE_LINEAR = 1'b0;
  localparam logic MODE_INTERLEAVED = 1'b1;

  // Cycle state of the bus, one-hot.
  typedef enum logic [3:0] {
    SSD_IDLE = 4'h1,
    SSD_READ = 4'h2,
    SSD_WRITE = 4'h4,
    SSD_SLEEP = 4'h8
  } ssd_state_t;

endpackage : ssd_pkg

`default_nettype wire

// ### design/ssd_sram.sv
// Cycle decoder, burst counter, byte-lane write and output pipeline of a burst SRAM.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Deselect on strobe with inactive chip selects; no address used, bus undriven.
// - Begin read at pin address on processor strobe, or controller strobe without write.
// - Active read with strobes idle and advance low continues at next burst address.
// - Active read with strobes idle and advance high re-reads current address.
// - Read cycles drive the bus only while output enable is low.
// - Output enable gates the drivers directly and is never clocked.
// - Begin write at pin address on controller strobe, or at current address in burst.
// - Burst write with advance low writes next address; bus stays undriven.
// - Burst write with advance high keeps the current address; bus stays undriven.
// - Sleep request overrides everything; no address, bus undriven.
// - Global write low writes all lanes; both write controls high means read.
// - With byte write enabled each lane is written by its own select.
// - Narrow configuration has two lanes of eight data bits plus one parity bit.
// - Either three chip selects or a single primary select, by parameter.
// - Two-bit wrapping burst counter, interleaved or linear order by mode input.
// - Processor-strobe writes take two cycles; controls sampled at the second edge.
// - After a deselect the drivers release only after the following edge.
// - Sleep entry and exit take two cycles; controller keeps the bus idle around it.
////////////////////////////////////////////////////////////////////////////////

module ssd_sram #(
  parameter int LANES = ssd_pkg::LANES_X36,
  parameter int ADDR_W = ssd_pkg::ADDR_W_X36,
  parameter bit SINGLE_CS = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_request,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_high_active,
  input wire logic chip_select_tertiary_n,
  input wire logic processor_address_strobe_n,
  input wire logic controller_address_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic burst_mode,
  input wire logic output_enable_n,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [LANES*ssd_pkg::BYTE_W-1:0] data_in,
  output logic [LANES*ssd_pkg::BYTE_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [LANES-1:0] parity_io_in,
  output logic [LANES-1:0] parity_io_out,
  output logic parity_io_oe_n
);

  localparam int WORD_W = LANES * ssd_pkg::LANE_W;
  localparam int DATA_W = LANES * ssd_pkg::BYTE_W;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int HIGH_W = ADDR_W - ssd_pkg::STEP_W;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [1:0] ssd_burst_low(input logic [1:0] seed, input logic [1:0] step,
                                               input logic mode);
    if (mode == ssd_pkg::MODE_INTERLEAVED) begin
      ssd_burst_low = seed ^ step;
    end else begin
      ssd_burst_low = seed + step;
    end
  endfunction : ssd_burst_low

  function automatic logic [LANES-1:0] ssd_lane_mask(input logic gw_n, input logic bwe_n,
                                                     input logic [LANES-1:0] sel_n);
    if (!gw_n) begin
      ssd_lane_mask = '1;
    end else if (!bwe_n) begin
      ssd_lane_mask = ~sel_n;
    end else begin
      ssd_lane_mask = '0;
    end
  endfunction : ssd_lane_mask

  // Priority shared by every state: sleep, then deselect, then write, then read.
  function automatic ssd_pkg::ssd_state_t ssd_pick(input ssd_pkg::ssd_state_t hold, input logic sleep_now,
                                                   input logic desel_now, input logic wr_now,
                                                   input logic rd_now);
    if (sleep_now) begin
      ssd_pick = ssd_pkg::SSD_SLEEP;
    end else if (desel_now) begin
      ssd_pick = ssd_pkg::SSD_IDLE;
    end else if (wr_now) begin
      ssd_pick = ssd_pkg::SSD_WRITE;
    end else if (rd_now) begin
      ssd_pick = ssd_pkg::SSD_READ;
    end else begin
      ssd_pick = hold;
    end
  endfunction : ssd_pick

  ////////////////////////////////////////////////////////////////////////////////
  // Asynchronous level inputs. Sleep and mode come from outside the clock, so
  // each passes two flip-flops; the two stages also give the two-cycle sleep entry.

  logic sleep_meta_reg;
  logic sleep_sync_reg;
  logic mode_meta_reg;
  logic mode_sync_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sleep_meta_reg <= 1'b0;
      sleep_sync_reg <= 1'b0;
      mode_meta_reg <= ssd_pkg::MODE_LINEAR;
      mode_sync_reg <= ssd_pkg::MODE_LINEAR;
    end else begin
      sleep_meta_reg <= sleep_request;
      sleep_sync_reg <= sleep_meta_reg;
      mode_meta_reg <= burst_mode;
      mode_sync_reg <= mode_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle decode. The strobes, selects and write controls are synchronous to
  // clk from the controller and are decoded at the edge without synchronisers.

  ssd_pkg::ssd_state_t state_reg;
  ssd_pkg::ssd_state_t state_next;
  logic [1:0] seed_reg;
  logic [1:0] step_reg;
  logic [1:0] step_next;
  logic [HIGH_W-1:0] high_reg;
  logic [ADDR_W-1:0] addr_reg;

  wire cs1_on = !chip_select_primary_n;
  wire cs_all_on = SINGLE_CS ? cs1_on
                             : (cs1_on && chip_select_high_active && !chip_select_tertiary_n);
  wire processor_address_strobe_on = !processor_address_strobe_n && cs1_on;
  wire controller_address_strobe_on = !controller_address_strobe_n;
  wire [LANES-1:0] lane_mask = ssd_lane_mask(global_write_n, byte_write_enable_n, lane_write_select_n);
  wire write_req = |lane_mask;

  wire sleeping = sleep_sync_reg;
  wire deselect = !sleeping && (controller_address_strobe_on || processor_address_strobe_on) && !cs_all_on;
  wire begin_read = !sleeping && cs_all_on && (processor_address_strobe_on || (controller_address_strobe_on && !write_req));
  wire begin_write_ext = !sleeping && cs_all_on && !processor_address_strobe_on && controller_address_strobe_on && write_req;
  wire strobes_idle = !controller_address_strobe_on && !processor_address_strobe_on;
  wire in_burst = (state_reg == ssd_pkg::SSD_READ) || (state_reg == ssd_pkg::SSD_WRITE);
  wire burst_cycle = !sleeping && strobes_idle && in_burst;
  wire advance = !burst_advance_n;
  // Burst writes need the write controls at this edge, which gives the
  // processor-strobe write its second cycle.
  wire burst_write = burst_cycle && write_req;
  wire burst_read = burst_cycle && !write_req;
  wire ext_load = begin_read || begin_write_ext;
  wire write_now = begin_write_ext || burst_write;
  wire read_now = begin_read || burst_read;

  always_comb begin
    if (ext_load) begin
      step_next = ssd_pkg::STEP_ZERO;
    end else if (burst_cycle && advance) begin
      step_next = step_reg + ssd_pkg::STEP_ONE;
    end else begin
      step_next = step_reg;
    end
  end

  // Only the two low bits walk; the upper bits stay as loaded by the strobe.
  // Mode is treated as a static strap: changing it inside a burst gives a mixed order.
  wire [ssd_pkg::STEP_W-1:0] burst_low = ssd_burst_low(seed_reg, step_next, mode_sync_reg);
  wire [ADDR_W-1:0] burst_addr = {high_reg, burst_low};
  wire [ADDR_W-1:0] access_addr = ext_load ? address : burst_addr;

  always_comb begin
    case (state_reg)
      ssd_pkg::SSD_IDLE: begin
        state_next = ssd_pick(ssd_pkg::SSD_IDLE, sleeping, deselect, write_now, read_now);
      end
      ssd_pkg::SSD_READ, ssd_pkg::SSD_WRITE: begin
        // Idle strobes inside a burst decode as a continue or a suspend unless sleep is active.
        state_next = ssd_pick(state_reg, sleeping, deselect, write_now, read_now);
      end
      ssd_pkg::SSD_SLEEP: begin
        // Leaving sleep lands in idle, so a fresh strobe is needed to start again.
        state_next = ssd_pick(ssd_pkg::SSD_IDLE, sleeping, deselect, write_now, read_now);
      end
      default: begin
        state_next = ssd_pkg::SSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ssd_pkg::SSD_IDLE;
      step_reg <= ssd_pkg::STEP_ZERO;
      seed_reg <= ssd_pkg::STEP_ZERO;
      high_reg <= '0;
      addr_reg <= '0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      if (ext_load) begin
        seed_reg <= address[ssd_pkg::STEP_W-1:0];
        high_reg <= address[ADDR_W-1:ssd_pkg::STEP_W];
      end
      if (read_now || write_now) begin
        addr_reg <= access_addr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Array. Each lane holds eight data bits and its parity bit side by side.

  logic [WORD_W-1:0] mem [DEPTH];
  logic [WORD_W-1:0] write_word;

  // Each lane is stored as its parity bit above its data byte.
  always_comb begin
    write_word = '0;
    for (int l = 0; l < LANES; l++) begin
      write_word[l*ssd_pkg::LANE_W +: ssd_pkg::LANE_W] =
        {parity_io_in[l], data_in[l*ssd_pkg::BYTE_W +: ssd_pkg::BYTE_W]};
    end
  end

  // The array has no reset, so no write may land while reset is held.
  wire array_we = reset_n && write_now;
  wire [LANES-1:0] lane_we = array_we ? lane_mask : '0;

  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (lane_we[l]) begin
        mem[access_addr][l*ssd_pkg::LANE_W +: ssd_pkg::LANE_W] <=
          write_word[l*ssd_pkg::LANE_W +: ssd_pkg::LANE_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output pipeline. A read decoded at one edge is fetched into the output
  // register at the next; the first cycle of an access is undriven, except after a read, which leaves its last word driven.

  logic [DATA_W-1:0] data_out_reg;
  logic [LANES-1:0] parity_out_reg;
  logic drive_reg;
  logic [WORD_W-1:0] fetch_word;
  logic [DATA_W-1:0] fetch_data;
  logic [LANES-1:0] fetch_parity;

  // There is no write pass-through: a read right after a write sees the array.
  always_comb begin
    fetch_word = mem[addr_reg];
    fetch_data = '0;
    fetch_parity = '0;
    for (int l = 0; l < LANES; l++) begin
      fetch_data[l*ssd_pkg::BYTE_W +: ssd_pkg::BYTE_W] = fetch_word[l*ssd_pkg::LANE_W +: ssd_pkg::BYTE_W];
      fetch_parity[l] = fetch_word[l*ssd_pkg::LANE_W + ssd_pkg::BYTE_W];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_out_reg <= '0;
      parity_out_reg <= '0;
    end else if (state_reg == ssd_pkg::SSD_READ) begin
      data_out_reg <= fetch_data;
      parity_out_reg <= fetch_parity;
    end
  end

  // Drive follows the state decoded one edge earlier, so a deselect releases the
  // bus only after the following edge; a write or sleep releases it at once.
  wire drive_hold = (state_reg == ssd_pkg::SSD_READ) && !write_now && !sleeping;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_reg <= 1'b0;
    end else begin
      drive_reg <= drive_hold;
    end
  end

  // Output enable is combined without a clock: it must reach the drivers at pin
  // speed, which is why these two enables are the only unregistered outputs.
  wire pin_drive = drive_reg && !output_enable_n;

  assign data_out = data_out_reg;
  assign parity_io_out = parity_out_reg;
  assign data_oe_n = !pin_drive;
  assign parity_io_oe_n = !pin_drive;

endmodule : ssd_sram

`default_nettype wire

// ### sim/ssd_checker.sv
// Port-level checker for the burst SRAM cycle decoder.
`default_nettype none
module ssd_checker #(
  parameter int LANES = 4,
  parameter bit SINGLE_CS = 1'b0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sleep_request,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_high_active,
  input wire logic chip_select_tertiary_n,
  input wire logic processor_address_strobe_n,
  input wire logic controller_address_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [LANES-1:0] lane_write_select_n,
  input wire logic output_enable_n,
  input wire logic data_oe_n,
  input wire logic parity_io_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] sleep_q;
  wire sel_ok = !chip_select_primary_n && (SINGLE_CS || (chip_select_high_active && !chip_select_tertiary_n));
  wire idle = controller_address_strobe_n && (processor_address_strobe_n || chip_select_primary_n);
  wire wr_req = !global_write_n || (!byte_write_enable_n && !(&lane_write_select_n));
  // Sleep passes two flops inside, so the last three samples must be clear too.
  wire quiet = !sleep_request && sleep_q == 3'h0;
  wire desel = (!controller_address_strobe_n || !processor_address_strobe_n && !chip_select_primary_n) && !sel_ok;
  wire begin_rd = quiet && sel_ok && (!processor_address_strobe_n || !controller_address_strobe_n && !wr_req);
  wire idle_rd = quiet && idle && !wr_req;

  always_ff @(posedge clk) begin
    if (!reset_n) sleep_q <= 3'h0;
    else sleep_q <= {sleep_q[1:0], sleep_request};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  sequence begin_rd_s; begin_rd; endsequence
  sequence idle_rd_s; idle_rd; endsequence

  oe_async_a: assert property (output_enable_n |-> data_oe_n) else $error("drive without output enable");
  oe_pair_a: assert property (parity_io_oe_n == data_oe_n) else $error("parity drive differs");
  sleep_hiz_a: assert property (sleep_request [*4] |=> data_oe_n) else $error("drive in sleep");
  cwrite_hiz_a: assert property (quiet && wr_req && sel_ok && !controller_address_strobe_n
    && processor_address_strobe_n |=> data_oe_n) else $error("drive after write begin");
  bwrite_hiz_a: assert property (quiet && wr_req && idle |=> data_oe_n) else $error("drive in burst write");
  read_drive_a: assert property (begin_rd_s ##1 idle_rd_s ##1 !output_enable_n |-> !data_oe_n)
    else $error("read data not driven");
  burst_drive_a: assert property (!data_oe_n && !$past(desel) and idle_rd_s ##1 !output_enable_n |-> !data_oe_n)
    else $error("burst read dropped drive");
  desel_hiz_a: assert property (desel |-> ##2 data_oe_n) else $error("drive after deselect");
endmodule : ssd_checker
`default_nettype wire

// ### sim/ssd_host_bus.sv
// Controller side of the shared data pins: resolves who drives them.
`default_nettype none
module ssd_host_bus (
  input wire logic clk,
  input wire logic host_drive,
  input wire logic [35:0] host_word,
  input wire logic [35:0] dev_word,
  input wire logic dev_oe_n,
  output logic [35:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] last_reg = 36'h0;
  // A released bus flips every cycle so a stale value can never pass for data.
  assign bus = host_drive ? host_word : (!dev_oe_n ? dev_word : ~last_reg);
  always_ff @(posedge clk) last_reg <= bus;
endmodule : ssd_host_bus
`default_nettype wire

// ### sim/sync_burst_sram_cycle_decode_tb.sv
// Testbench for the burst SRAM cycle decoder.
`default_nettype none
module sync_burst_sram_cycle_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, sleep_request = 1'b0, burst_mode = 1'b0, output_enable_n = 1'b0;
  logic chip_select_primary_n, chip_select_high_active, chip_select_tertiary_n, host_drive;
  logic processor_address_strobe_n, controller_address_strobe_n, burst_advance_n;
  logic global_write_n, byte_write_enable_n, data_oe_n, parity_io_oe_n;
  logic [3:0] lane_write_select_n, parity_io_in, parity_io_out;
  logic [2:0] sel;
  logic [5:0] address;
  logic [31:0] data_in, data_out;
  logic [35:0] host_word;
  logic [15:0] narrow_data;
  logic [1:0] narrow_parity;
  logic narrow_oe_n, narrow_parity_oe_n;
  int bad_count = 0, checks = 0;
  assign {chip_select_tertiary_n, chip_select_high_active, chip_select_primary_n} = sel;
  ssd_sram #(.ADDR_W(6)) dut (.clk(clk), .reset_n(reset_n), .sleep_request(sleep_request),
    .chip_select_primary_n(chip_select_primary_n), .chip_select_high_active(chip_select_high_active),
    .chip_select_tertiary_n(chip_select_tertiary_n), .processor_address_strobe_n(processor_address_strobe_n),
    .controller_address_strobe_n(controller_address_strobe_n), .burst_advance_n(burst_advance_n),
    .global_write_n(global_write_n), .byte_write_enable_n(byte_write_enable_n),
    .lane_write_select_n(lane_write_select_n), .burst_mode(burst_mode), .output_enable_n(output_enable_n),
    .address(address), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .parity_io_in(parity_io_in), .parity_io_out(parity_io_out), .parity_io_oe_n(parity_io_oe_n));
  // Narrow single-select copy on the same pins; it is observed only and never drives the bus.
  ssd_sram #(.LANES(2), .ADDR_W(6), .SINGLE_CS(1'b1)) dut_narrow (.clk(clk), .reset_n(reset_n),
    .sleep_request(sleep_request), .chip_select_primary_n(chip_select_primary_n),
    .chip_select_high_active(chip_select_high_active), .chip_select_tertiary_n(chip_select_tertiary_n),
    .processor_address_strobe_n(processor_address_strobe_n),
    .controller_address_strobe_n(controller_address_strobe_n), .burst_advance_n(burst_advance_n),
    .global_write_n(global_write_n), .byte_write_enable_n(byte_write_enable_n),
    .lane_write_select_n(lane_write_select_n[1:0]), .burst_mode(burst_mode), .output_enable_n(output_enable_n),
    .address(address), .data_in(data_in[15:0]), .data_out(narrow_data), .data_oe_n(narrow_oe_n),
    .parity_io_in(parity_io_in[1:0]), .parity_io_out(narrow_parity), .parity_io_oe_n(narrow_parity_oe_n));
  ssd_host_bus host (.clk(clk), .host_drive(host_drive), .host_word(host_word),
    .dev_word({parity_io_out, data_out}), .dev_oe_n(data_oe_n), .bus({parity_io_in, data_in}));
  initial forever #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input logic [1:0] st, input logic burst_advance, input logic [5:0] wr, input logic [5:0] a,
      input logic [35:0] w);
    @(posedge clk);
    {processor_address_strobe_n, controller_address_strobe_n} <= st;
    burst_advance_n <= burst_advance;
    {global_write_n, byte_write_enable_n, lane_write_select_n} <= wr;
    address <= a;
    host_word <= w;
    host_drive <= wr != 6'h3f;
  endtask : cyc

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [5:0] a, input logic [35:0] e);
    cyc(2'b10, 1'b1, 6'h3f, a, 36'h0);
    cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
    @(posedge clk);
    #1 chk("word", e, {parity_io_out, data_out});
    chk("drive", 36'h0, 36'(data_oe_n));
    chk("narrow word", 36'({e[33:32], e[15:0]}), 36'({narrow_parity, narrow_data}));
  endtask : rdchk

  task automatic t_lanes;
    cyc(2'b10, 1'b1, 6'h1f, 6'h04, 36'h987654321);
    cyc(2'b10, 1'b1, 6'h2a, 6'h04, 36'h0aaaaaaaa);
    rdchk(6'h04, 36'h887aa43aa);
    @(posedge clk);
    #1 chk("word", 36'h887aa43aa, {parity_io_out, data_out});
    @(posedge clk);
    output_enable_n <= 1'b1;
    #1 chk("drive", 36'h1, 36'(data_oe_n));
    @(posedge clk);
    output_enable_n <= 1'b0;
    #1 chk("drive", 36'h0, 36'(data_oe_n));
    $display("lanes done");
  endtask : t_lanes

  task automatic t_burst;
    logic [7:0] seq;
    cyc(2'b10, 1'b1, 6'h1f, 6'h08, {9{4'h1}});
    for (int i = 2; i < 5; i++) cyc(2'b11, 1'b0, 6'h1f, 6'h0, {9{4'(i)}});
    for (int m = 0; m < 2; m++) begin
      // Start address ends in 01; first index leads in the top bits.
      seq = m ? 8'h4e : 8'h6c;
      burst_mode <= m[0];
      repeat (3) cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
      cyc(2'b10, 1'b1, 6'h3f, 6'h09, 36'h0);
      for (int k = 0; k < 5; k++) begin
        cyc(2'b11, 1'b0, 6'h3f, 6'h0, 36'h0);
        #1 if (k > 0) chk("burst", {9{{2'b00, seq[9-2*k -: 2]} + 4'h1}}, {parity_io_out, data_out});
      end
    end
    $display("burst done");
  endtask : t_burst

  task automatic t_desel;
    logic [8:0] pats = 9'b011_110_000;
    for (int i = 0; i < 3; i++) begin
      rdchk(6'h04, 36'h887aa43aa);
      cyc(2'b10, 1'b1, 6'h3f, 6'h0, 36'h0);
      sel <= pats[8-3*i -: 3];
      cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
      sel <= 3'b010;
      #1 chk("drive", 36'h0, 36'(data_oe_n));
      @(posedge clk);
      #1 chk("drive", 36'h1, 36'(data_oe_n));
      chk("narrow drive", 36'(i == 0), 36'(narrow_oe_n));
    end
    $display("deselect done");
  endtask : t_desel

  task automatic t_pwrite;
    cyc(2'b01, 1'b1, 6'h3f, 6'h14, 36'h0);
    cyc(2'b11, 1'b1, 6'h1f, 6'h0, 36'h5a5a5a5a5);
    rdchk(6'h14, 36'h5a5a5a5a5);
    $display("processor write done");
  endtask : t_pwrite

  task automatic t_sleep;
    cyc(2'b10, 1'b1, 6'h3f, 6'h0, 36'h0);
    sel <= 3'b011;
    cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
    sel <= 3'b010;
    sleep_request <= 1'b1;
    repeat (3) cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
    repeat (3) cyc(2'b10, 1'b1, 6'h3f, 6'h04, 36'h0);
    repeat (2) cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
    #1 chk("drive", 36'h1, 36'(data_oe_n));
    sleep_request <= 1'b0;
    repeat (3) cyc(2'b11, 1'b1, 6'h3f, 6'h0, 36'h0);
    rdchk(6'h04, 36'h887aa43aa);
    $display("sleep done");
  endtask : t_sleep

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  initial begin
    sel = 3'b010;
    {processor_address_strobe_n, controller_address_strobe_n, burst_advance_n} = 3'h7;
    {global_write_n, byte_write_enable_n, lane_write_select_n} = 6'h3f;
    address = 6'h0;
    host_word = 36'h0;
    host_drive = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_lanes();
    t_burst();
    t_desel();
    t_pwrite();
    t_sleep();
    conclude();
  end

  initial begin
    repeat (1000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : sync_burst_sram_cycle_decode_tb

bind ssd_sram ssd_checker #(.LANES(LANES), .SINGLE_CS(SINGLE_CS)) checker_i (.clk(clk), .reset_n(reset_n),
  .sleep_request(sleep_request), .chip_select_primary_n(chip_select_primary_n),
  .chip_select_high_active(chip_select_high_active), .chip_select_tertiary_n(chip_select_tertiary_n),
  .processor_address_strobe_n(processor_address_strobe_n),
  .controller_address_strobe_n(controller_address_strobe_n), .global_write_n(global_write_n),
  .byte_write_enable_n(byte_write_enable_n), .lane_write_select_n(lane_write_select_n),
  .output_enable_n(output_enable_n), .data_oe_n(data_oe_n), .parity_io_oe_n(parity_io_oe_n));
`default_nettype wire
